// ===== rtl/enclave_ext_state_manager.sv
// Enclave extended-state manager with APB register access
// Overview of operation
// - Unblocked vectored events inside the enclave cause an asynchronous exit.
// - Breakpoint and rendezvous also exit; teardown message never exits.
// - Only the first triggering event is recorded; later ones leave it.
// - Entry checks mask against enable register, saves it, loads mask.
// - Leaving the enclave restores the enable register saved at entry.
// - Exit saves mask-selected state to the frame, then synthesizes it.
// - Resume reloads mask-selected state from the save frame.
// - Create computes needed frame size and checks declared frame pages.
// - Init requires signature values match under the signature masks.
// - Mask low two bits must be one; otherwise illegal.
// - Without save support, mask bits 63 to 2 must be zero.
// - With save support, mask must be a legal enable-register value.
// - Inside the enclave exactly the mask-selected states are enabled.
// - Extended area is always in standard non-compacted layout.
// - Without save support area is 576 bytes; mask copied at 512.
// - With save support, length walks set components from 576 onward.
// - Extended-state area sits at byte offset 0 of each frame.
// - Misc area sits directly in front of the register area.
// - Every report carries the mask and misc select value; the code reports only mask bits 31 to 0.
// - Key derivation mixes only mask and misc bits chosen by masks.
// - Entry faults with code zero if mask asks unenabled features.
// - After exit save, enable register returns to entry-time value.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module enclave_ext_state_manager
   import xstate_pkg::*;
#(
   parameter logic [63:0] SUPPORTED_MASK = 64'h7FFF_FFFF_FFFF_FFFF,
   parameter logic [31:0] GPR_BYTES      = 32'h0000_00B8
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Events from the core
   input  wire event_s      event_i,
   // Core-facing state
   output logic [63:0]      ext_state_enable_o,
   output logic             in_enclave_o,
   output frame_req_s       frame_req_o
);
   typedef enum {ST_IDLE, ST_SIZE, ST_SYNTH} state_e;

   state_e        state_reg;
   logic [31:0]   ctrl_reg, pages_reg, misc_sz_reg, misc_sel_reg;
   logic [31:0]   attr_reg, sig_attr_reg, sig_amsk_reg, sig_misc_reg;
   logic [31:0]   sig_mmsk_reg, key_amsk_reg, key_mmsk_reg;
   logic [31:0]   key_attr_reg, key_misc_reg, rpt_mask_reg, rpt_misc_reg;
   logic [31:0]   xlen_reg, cur_off_reg, cur_size_reg;
   logic [63:0]   mask_reg, xen_reg, saved_reg;
   logic [5:0]    comp_idx_reg, walk_reg;
   logic [31:0]   comp_tbl [64];
   logic [7:0]    evt_rec_reg;
   logic          busy_reg, fault_reg, in_enc_reg, created_reg;
   logic          pready_reg, pslverr_reg;
   logic [31:0]   prdata_reg;
   frame_req_s    frame_reg;

   // APB decode
   wire logic setup_ph = psel_i & ~penable_i;
   wire logic wr_en = psel_i & penable_i & pready_reg & pwrite_i;
   wire logic cfg_ok = ~in_enc_reg & ~busy_reg;
   logic [31:0] rdata;
   logic        mapped;
   always_comb begin
      mapped = 1'b1;
      unique case (paddr_i)
         CTRL_OFF:     rdata = ctrl_reg;
         STATUS_OFF:   rdata = {24'h0, evt_rec_reg[7], 3'h0,
                                created_reg, in_enc_reg, fault_reg,
                                busy_reg};
         MASK_LO_OFF:  rdata = mask_reg[31:0];
         MASK_HI_OFF:  rdata = mask_reg[63:32];
         XEN_LO_OFF:   rdata = xen_reg[31:0];
         XEN_HI_OFF:   rdata = xen_reg[63:32];
         SAVED_LO_OFF: rdata = saved_reg[31:0];
         SAVED_HI_OFF: rdata = saved_reg[63:32];
         PAGES_OFF:    rdata = pages_reg;
         MISC_SZ_OFF:  rdata = misc_sz_reg;
         MISC_SEL_OFF: rdata = misc_sel_reg;
         XLEN_OFF:     rdata = xlen_reg;
         COMP_IDX_OFF: rdata = {26'h0, comp_idx_reg};
         COMP_DAT_OFF: rdata = comp_tbl[comp_idx_reg];
         ATTR_OFF:     rdata = attr_reg;
         SIG_ATTR_OFF: rdata = sig_attr_reg;
         SIG_AMSK_OFF: rdata = sig_amsk_reg;
         SIG_MISC_OFF: rdata = sig_misc_reg;
         SIG_MMSK_OFF: rdata = sig_mmsk_reg;
         KEY_AMSK_OFF: rdata = key_amsk_reg;
         KEY_MMSK_OFF: rdata = key_mmsk_reg;
         KEY_ATTR_OFF: rdata = key_attr_reg;
         KEY_MISC_OFF: rdata = key_misc_reg;
         RPT_MASK_OFF: rdata = rpt_mask_reg;
         RPT_MISC_OFF: rdata = rpt_misc_reg;
         EVT_REC_OFF:  rdata = {24'h0, evt_rec_reg};
         CMD_OFF:      rdata = 32'h0000_0000;
         default: begin
            rdata  = 32'h0000_0000;
            mapped = 1'b0;
         end
      endcase
   end

   // Registered APB answer, one wait-free access phase
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= setup_ph;
         pslverr_reg <= setup_ph & ~mapped;
         if (setup_ph) begin
            prdata_reg <= rdata;
         end
      end
   end

   // Command and legality decode
   wire logic xs_sup = ctrl_reg[XS_SUP_BIT];
   wire logic xs_on = xs_sup & ctrl_reg[XS_OS_BIT];
   wire logic cmd_wr = wr_en & (paddr_i == CMD_OFF) & ~busy_reg;
   wire op_e  cmd_op = op_e'(pwdata_i[2:0]);
   wire logic low_ok = mask_reg[1:0] == LOW_BITS_REQ;
   wire logic hi_zero = mask_reg[63:2] == 62'h0;
   wire logic legal_x = ((mask_reg & ~SUPPORTED_MASK) == 64'h0)
                        & ~mask_reg[63];
   wire logic create_bad = ~low_ok | (~xs_on & (~hi_zero |
                           (pages_reg == 32'h0))) | (xs_on & ~legal_x);
   wire logic subset = (mask_reg & xen_reg) == mask_reg;
   wire logic entry_bad = ~created_reg | ~ctrl_reg[VEC_OS_BIT] | (xs_sup
                          & ((~ctrl_reg[XS_OS_BIT] & (mask_reg !=
                          MASK_RST)) | ~subset));
   wire logic init_bad = ((sig_attr_reg ^ attr_reg) & sig_amsk_reg) != 0
                         | ((sig_misc_reg ^ misc_sel_reg)
                         & sig_mmsk_reg) != 0;
   // Frame fit: misc area directly before register area
   wire logic [31:0] walk_end = cur_off_reg + cur_size_reg;
   wire logic [31:0] comp_off = {16'h0, comp_tbl[walk_reg][15:0]};
   wire logic [31:0] comp_sz = {16'h0, comp_tbl[walk_reg][31:16]};
   wire logic [31:0] need = walk_end + misc_sz_reg + GPR_BYTES;
   wire logic [31:0] have = pages_reg << PAGE_SHIFT;
   // Exit triggers
   wire logic ev_exit = event_i.valid & ~event_i.blocked
                        & ~event_i.teardown & in_enc_reg;

   // Configuration writes, refused while inside or busy
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_reg     <= 32'h0000_0000;
         pages_reg    <= 32'h0000_0000;
         misc_sz_reg  <= 32'h0000_0000;
         misc_sel_reg <= 32'h0000_0000;
         attr_reg     <= 32'h0000_0000;
         sig_attr_reg <= 32'h0000_0000;
         sig_amsk_reg <= 32'h0000_0000;
         sig_misc_reg <= 32'h0000_0000;
         sig_mmsk_reg <= 32'h0000_0000;
         key_amsk_reg <= 32'h0000_0000;
         key_mmsk_reg <= 32'h0000_0000;
         comp_idx_reg <= 6'h00;
      end else if (wr_en && cfg_ok) begin
         case (paddr_i)
            CTRL_OFF:     ctrl_reg     <= {29'h0, pwdata_i[2:0]};
            PAGES_OFF:    pages_reg    <= pwdata_i;
            MISC_SZ_OFF:  misc_sz_reg  <= pwdata_i;
            MISC_SEL_OFF: misc_sel_reg <= pwdata_i;
            ATTR_OFF:     attr_reg     <= pwdata_i;
            SIG_ATTR_OFF: sig_attr_reg <= pwdata_i;
            SIG_AMSK_OFF: sig_amsk_reg <= pwdata_i;
            SIG_MISC_OFF: sig_misc_reg <= pwdata_i;
            SIG_MMSK_OFF: sig_mmsk_reg <= pwdata_i;
            KEY_AMSK_OFF: key_amsk_reg <= pwdata_i;
            KEY_MMSK_OFF: key_mmsk_reg <= pwdata_i;
            COMP_IDX_OFF: comp_idx_reg <= pwdata_i[5:0];
            default: ;
         endcase
      end
   end

   // Component table: {size, offset} per feature bit
   always_ff @(posedge mclk_i) begin
      if (wr_en && cfg_ok && paddr_i == COMP_DAT_OFF) begin
         comp_tbl[comp_idx_reg] <= pwdata_i;
      end
   end

   // Operation sequencer
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg    <= ST_IDLE;
         busy_reg     <= 1'b0;
         fault_reg    <= 1'b0;
         in_enc_reg   <= 1'b0;
         created_reg  <= 1'b0;
         mask_reg     <= MASK_RST;
         xen_reg      <= XEN_RST;
         saved_reg    <= XEN_RST;
         walk_reg     <= FIRST_COMP;
         cur_off_reg  <= LEGACY_LEN;
         cur_size_reg <= 32'h0000_0000;
         xlen_reg     <= LEGACY_LEN;
         evt_rec_reg  <= 8'h00;
         key_attr_reg <= 32'h0000_0000;
         key_misc_reg <= 32'h0000_0000;
         rpt_mask_reg <= 32'h0000_0000;
         rpt_misc_reg <= 32'h0000_0000;
         frame_reg    <= '0;
      end else begin
         frame_reg.save    <= 1'b0;
         frame_reg.synth   <= 1'b0;
         frame_reg.restore <= 1'b0;
         frame_reg.copy_wr <= 1'b0;
         if (wr_en && cfg_ok) begin
            if (paddr_i == MASK_LO_OFF) mask_reg[31:0]  <= pwdata_i;
            if (paddr_i == MASK_HI_OFF) mask_reg[63:32] <= pwdata_i;
            if (paddr_i == XEN_LO_OFF)  xen_reg[31:0]   <= pwdata_i;
            if (paddr_i == XEN_HI_OFF)  xen_reg[63:32]  <= pwdata_i;
         end
         case (state_reg)
            ST_IDLE: begin
               if (ev_exit) begin
                  // First event wins; busy blocks any later one
                  evt_rec_reg <= {1'b1, 4'h0, event_i.kind};
                  frame_reg.save      <= 1'b1;
                  frame_reg.mask      <= mask_reg;
                  frame_reg.copy_wr   <= ~xs_on;
                  frame_reg.copy_addr <= XAREA_OFF + MASK_COPY_OFF;
                  busy_reg  <= 1'b1;
                  state_reg <= ST_SYNTH;
               end else if (cmd_wr) begin
                  case (cmd_op)
                     OP_CREATE: begin
                        fault_reg <= create_bad;
                        if (!create_bad) begin
                           busy_reg     <= 1'b1;
                           walk_reg     <= FIRST_COMP;
                           cur_off_reg  <= LEGACY_LEN;
                           cur_size_reg <= 32'h0000_0000;
                           state_reg    <= ST_SIZE;
                        end
                     end
                     OP_ENTER, OP_RESUME: begin
                        fault_reg <= entry_bad | in_enc_reg;
                        if (!entry_bad && !in_enc_reg) begin
                           saved_reg  <= xen_reg;
                           xen_reg    <= mask_reg;
                           in_enc_reg <= 1'b1;
                           evt_rec_reg <= 8'h00;
                           frame_reg.restore <= cmd_op == OP_RESUME;
                           frame_reg.mask    <= mask_reg;
                        end
                     end
                     OP_EXIT: begin
                        fault_reg <= ~in_enc_reg;
                        if (in_enc_reg) begin
                           xen_reg    <= saved_reg;
                           in_enc_reg <= 1'b0;
                        end
                     end
                     OP_INIT: fault_reg <= init_bad | ~created_reg;
                     OP_REPORT: begin
                        rpt_mask_reg <= mask_reg[31:0];
                        rpt_misc_reg <= misc_sel_reg;
                        fault_reg    <= 1'b0;
                     end
                     OP_KEY: begin
                        key_attr_reg <= mask_reg[31:0] & key_amsk_reg;
                        key_misc_reg <= misc_sel_reg & key_mmsk_reg;
                        fault_reg    <= 1'b0;
                     end
                     default: ;
                  endcase
               end
            end
            ST_SIZE: begin
               // Walk standard-format components, one bit per cycle
               if (xs_on && mask_reg[walk_reg]
                   && comp_off >= walk_end) begin
                  cur_off_reg  <= comp_off;
                  cur_size_reg <= comp_sz;
               end
               if (walk_reg == LAST_COMP) begin
                  state_reg <= ST_IDLE;
                  busy_reg  <= 1'b0;
                  xlen_reg  <= walk_end;
                  fault_reg <= need > have;
                  created_reg <= ~(need > have);
               end else begin
                  walk_reg <= walk_reg + 6'h01;
               end
            end
            ST_SYNTH: begin
               frame_reg.synth <= 1'b1;
               xen_reg    <= saved_reg;
               in_enc_reg <= 1'b0;
               busy_reg   <= 1'b0;
               state_reg  <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Outputs from flops
   assign prdata_o           = prdata_reg;
   assign pready_o           = pready_reg;
   assign pslverr_o          = pslverr_reg;
   assign ext_state_enable_o = xen_reg;
   assign in_enclave_o       = in_enc_reg;
   assign frame_req_o        = frame_reg;

   // Checks
   sequence s_exit_start;
      state_reg == ST_IDLE && ev_exit;
   endsequence
   sequence s_save_then_synth;
      frame_req_o.save ##1 frame_req_o.synth;
   endsequence
   a_exit_sequence: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) s_exit_start |=> s_save_then_synth)
      else $error("exit did not save then synthesize");
   a_exit_restore: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) s_exit_start ##1 1 |=>
      ext_state_enable_o == $past(saved_reg) && !in_enclave_o)
      else $error("enable register not restored after exit");
   a_first_event: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) state_reg == ST_SYNTH |=>
      evt_rec_reg == $past(evt_rec_reg))
      else $error("event record changed during exit");
   a_teardown_stays: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) event_i.valid && event_i.teardown && !busy_reg
      && !cmd_wr |=> !frame_req_o.save)
      else $error("teardown message caused exit");
   a_enter_swap: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) state_reg == ST_IDLE && !ev_exit && cmd_wr
      && cmd_op == OP_ENTER && !entry_bad && !in_enc_reg |=>
      ext_state_enable_o == $past(mask_reg)
      && saved_reg == $past(xen_reg))
      else $error("entry did not swap enable register");
   a_enter_fault: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) state_reg == ST_IDLE && !ev_exit && cmd_wr
      && cmd_op == OP_ENTER && !subset && xs_sup |=>
      fault_reg && $stable(saved_reg) && $stable(in_enclave_o))
      else $error("bad entry not faulted");
   a_inside_mask: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) in_enclave_o && !busy_reg |->
      ext_state_enable_o == mask_reg)
      else $error("enabled state differs from mask inside");
   a_low_bits: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) state_reg == ST_IDLE && !ev_exit && cmd_wr
      && cmd_op == OP_CREATE && !low_ok |=> fault_reg
      && state_reg == ST_IDLE)
      else $error("illegal low mask bits accepted");
   a_size_walk: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) $rose(state_reg == ST_SIZE) |-> ##61
      state_reg == ST_SIZE ##1 state_reg == ST_IDLE)
      else $error("size walk length wrong");
   a_mask_copy: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) frame_req_o.copy_wr |->
      frame_req_o.copy_addr == 32'h0000_0200 && frame_req_o.save)
      else $error("mask copy misplaced");
   a_apb_answer: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) psel_i && !penable_i |=> pready_o)
      else $error("access phase not answered");
endmodule : enclave_ext_state_manager
`default_nettype wire

// ===== rtl/xstate_pkg.sv
// Shared constants and types for the enclave extended-state manager
package xstate_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF      = 8'h00;
   localparam logic [7:0] CMD_OFF       = 8'h04;
   localparam logic [7:0] STATUS_OFF    = 8'h08;
   localparam logic [7:0] MASK_LO_OFF   = 8'h0C;
   localparam logic [7:0] MASK_HI_OFF   = 8'h10;
   localparam logic [7:0] XEN_LO_OFF    = 8'h14;
   localparam logic [7:0] XEN_HI_OFF    = 8'h18;
   localparam logic [7:0] SAVED_LO_OFF  = 8'h1C;
   localparam logic [7:0] SAVED_HI_OFF  = 8'h20;
   localparam logic [7:0] PAGES_OFF     = 8'h24;
   localparam logic [7:0] MISC_SZ_OFF   = 8'h28;
   localparam logic [7:0] MISC_SEL_OFF  = 8'h2C;
   localparam logic [7:0] XLEN_OFF      = 8'h30;
   localparam logic [7:0] COMP_IDX_OFF  = 8'h34;
   localparam logic [7:0] COMP_DAT_OFF  = 8'h38;
   localparam logic [7:0] ATTR_OFF      = 8'h3C;
   localparam logic [7:0] SIG_ATTR_OFF  = 8'h40;
   localparam logic [7:0] SIG_AMSK_OFF  = 8'h44;
   localparam logic [7:0] SIG_MISC_OFF  = 8'h48;
   localparam logic [7:0] SIG_MMSK_OFF  = 8'h4C;
   localparam logic [7:0] KEY_AMSK_OFF  = 8'h50;
   localparam logic [7:0] KEY_MMSK_OFF  = 8'h54;
   localparam logic [7:0] KEY_ATTR_OFF  = 8'h58;
   localparam logic [7:0] KEY_MISC_OFF  = 8'h5C;
   localparam logic [7:0] RPT_MASK_OFF  = 8'h60;
   localparam logic [7:0] RPT_MISC_OFF  = 8'h64;
   localparam logic [7:0] EVT_REC_OFF   = 8'h68;
   // CTRL field positions
   localparam int XS_SUP_BIT = 0;
   localparam int XS_OS_BIT  = 1;
   localparam int VEC_OS_BIT = 2;
   // Fixed layout figures
   localparam logic [1:0]  LOW_BITS_REQ  = 2'h3;
   localparam logic [31:0] LEGACY_LEN    = 32'h0000_0240; // 576 bytes
   localparam logic [31:0] MASK_COPY_OFF = 32'h0000_0200; // 512
   localparam logic [31:0] XAREA_OFF     = 32'h0000_0000;
   localparam int          PAGE_SHIFT    = 12;
   localparam logic [5:0]  FIRST_COMP    = 6'h02;
   localparam logic [5:0]  LAST_COMP     = 6'h3F;
   // Reset values
   localparam logic [63:0] MASK_RST = 64'h0000_0000_0000_0003;
   localparam logic [63:0] XEN_RST  = 64'h0000_0000_0000_0003;
   // Operations started through CMD
   typedef enum logic [2:0] {
      OP_NONE, OP_CREATE, OP_ENTER, OP_RESUME,
      OP_EXIT, OP_INIT, OP_REPORT, OP_KEY
   } op_e;
   // Vectored event kinds
   typedef enum logic [2:0] {
      EV_EXCEPTION, EV_INTERRUPT, EV_SMI, EV_NMI, EV_INIT,
      EV_VMEXIT, EV_BREAKPOINT, EV_RENDEZVOUS
   } ev_kind_e;
   // Event input bundle
   typedef struct packed {
      logic     valid;
      logic     blocked;
      logic     teardown;
      ev_kind_e kind;
   } event_s;
   // Save-area request bundle
   typedef struct packed {
      logic        save;
      logic        synth;
      logic        restore;
      logic        copy_wr;
      logic [31:0] copy_addr;
      logic [63:0] mask;
   } frame_req_s;
endpackage : xstate_pkg

// ===== tb/tb_top.sv
// Register-level testbench for the enclave extended-state manager
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import xstate_pkg::*;
;
   logic        mclk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   event_s      ev_sig = '0;
   logic [63:0] xen;
   logic        in_enc;
   frame_req_s  freq;
   logic [31:0] rd;
   logic        err;
   int          num_errors = 0;
   int          compares = 0;
   int          n_save = 0;
   int          n_synth = 0;
   int          n_rest = 0;
   int          n_copy = 0;

   enclave_ext_state_manager enclave_ext_state_manager_inst (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .event_i(ev_sig), .ext_state_enable_o(xen),
      .in_enclave_o(in_enc), .frame_req_o(freq));

   // Clock at 100 MHz
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   // Counts one-cycle frame request pulses
   always @(posedge mclk_i) begin
      n_save  += (freq.save === 1'b1);
      n_synth += (freq.synth === 1'b1);
      n_rest  += (freq.restore === 1'b1);
      n_copy  += (freq.copy_wr === 1'b1);
   end

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [63:0] seen,
                      input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      // Only pready or the watchdog ends a wait for the answer
      do begin
         @(posedge mclk_i);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // Issues a command and waits while busy
   task automatic cmd(input op_e op);
      apb(1'b1, CMD_OFF, {29'h0, op});
      apb(1'b0, STATUS_OFF, 32'h0);
      while (rd[0] !== 1'b0) begin
         apb(1'b0, STATUS_OFF, 32'h0);
      end
   endtask : cmd

   task automatic ev(input ev_kind_e k, input logic b, input logic t);
      @(posedge mclk_i);
      ev_sig <= {1'b1, b, t, k};
      @(posedge mclk_i);
      ev_sig.valid <= 1'b0;
      repeat (4) @(posedge mclk_i);
   endtask : ev

   // Watchdog against hangs
   initial begin
      #400000;
      num_errors++;
      wrap_up();
   end

   initial begin
      repeat (16) @(posedge mclk_i);
      resetn_i <= 1'b1;
      apb(1'b0, MASK_LO_OFF, 0); chk("mask", rd, 32'h3);
      apb(1'b0, XLEN_OFF, 0); chk("xlen", rd, LEGACY_LEN);
      chk("xen", xen, XEN_RST);
      apb(1'b0, 8'hFC, 0); chk("unmapped", {err, rd}, 33'h1_0000_0000);
      wr(CTRL_OFF, 32'h7);
      wr(XEN_LO_OFF, 32'h7);
      wr(MASK_LO_OFF, 32'h1);
      cmd(OP_CREATE); chk("bad low bits", rd[1], 1'b1);
      wr(MASK_LO_OFF, 32'h3); wr(PAGES_OFF, 32'h0);
      cmd(OP_CREATE); chk("zero pages", rd[1], 1'b1);
      wr(PAGES_OFF, 32'h1);
      cmd(OP_CREATE); chk("created", rd[3:1], 3'b100);
      apb(1'b0, XLEN_OFF, 0); chk("xlen", rd, LEGACY_LEN);
      cmd(OP_ENTER); chk("in", in_enc, 1'b1);
      chk("xen in", xen, 64'h3);
      apb(1'b0, SAVED_LO_OFF, 0); chk("saved", rd, 32'h7);
      ev(EV_INTERRUPT, 1'b1, 1'b0); chk("blocked", in_enc, 1'b1);
      ev(EV_RENDEZVOUS, 1'b0, 1'b1); chk("teardown", in_enc, 1'b1);
      // Two events back to back: only the first is recorded
      @(posedge mclk_i);
      ev_sig <= {1'b1, 1'b0, 1'b0, EV_NMI};
      ev(EV_VMEXIT, 1'b0, 1'b0);
      chk("exit", in_enc, 1'b0);
      chk("xen back", xen, 64'h7);
      chk("save synth", {n_save, n_synth}, {32'd1, 32'd1});
      chk("frame mask", freq.mask, 64'h3);
      apb(1'b0, EVT_REC_OFF, 0); chk("record", rd[2:0], EV_NMI);
      apb(1'b0, STATUS_OFF, 0); chk("recorded", rd[7], 1'b1);
      for (int k = 0; k < 8; k++) begin
         cmd(OP_RESUME); chk("restore", n_rest, k + 1);
         ev(ev_kind_e'(k), 1'b0, 1'b0); chk("kind exit", in_enc, 1'b0);
      end
      cmd(OP_ENTER); cmd(OP_EXIT);
      chk("leave", in_enc, 1'b0);
      chk("leave xen", xen, 64'h7);
      wr(XEN_LO_OFF, 32'h3); wr(MASK_LO_OFF, 32'h7);
      cmd(OP_ENTER); chk("enter fault", {rd[1], in_enc}, 2'b10);
      apb(1'b0, SAVED_LO_OFF, 0); chk("saved kept", rd, 32'h7);
      wr(MASK_LO_OFF, 32'h3); wr(CTRL_OFF, 32'h5);
      cmd(OP_ENTER); ev(EV_SMI, 1'b0, 1'b0);
      chk("copy", n_copy, 1);
      chk("copy addr", freq.copy_addr, MASK_COPY_OFF);
      wr(MISC_SEL_OFF, 32'h5); wr(KEY_AMSK_OFF, 32'h1);
      wr(KEY_MMSK_OFF, 32'h4);
      cmd(OP_REPORT); cmd(OP_KEY);
      apb(1'b0, RPT_MASK_OFF, 0); chk("rpt mask", rd, 32'h3);
      apb(1'b0, RPT_MISC_OFF, 0); chk("rpt misc", rd, 32'h5);
      apb(1'b0, KEY_ATTR_OFF, 0); chk("key attr", rd, 32'h1);
      apb(1'b0, KEY_MISC_OFF, 0); chk("key misc", rd, 32'h4);
      wr(ATTR_OFF, 32'h3); wr(SIG_ATTR_OFF, 32'h1); wr(SIG_AMSK_OFF, 32'h1);
      wr(SIG_MISC_OFF, 32'h5); wr(SIG_MMSK_OFF, 32'hF);
      cmd(OP_INIT); chk("init ok", rd[1], 1'b0);
      wr(SIG_ATTR_OFF, 32'h0); wr(SIG_AMSK_OFF, 32'h2);
      cmd(OP_INIT); chk("init bad", rd[1], 1'b1);
      // Walk: bit 2 lands at the running end, bit 3 lies below it
      wr(CTRL_OFF, 32'h7);
      wr(COMP_IDX_OFF, 32'h2);
      wr(COMP_DAT_OFF, 32'h0100_0240);
      wr(COMP_IDX_OFF, 32'h3);
      wr(COMP_DAT_OFF, 32'h0040_0200);
      wr(MASK_LO_OFF, 32'hF);
      cmd(OP_CREATE); chk("walk", rd[3:1], 3'b100);
      apb(1'b0, XLEN_OFF, 0); chk("xlen walk", rd, 32'h340);
      // Upper mask bits without save support enabled
      wr(CTRL_OFF, 32'h5);
      cmd(OP_CREATE); chk("hi bits", rd[1], 1'b1);
      wr(CTRL_OFF, 32'h7);
      // Frame exactly one page, then one byte over
      wr(MISC_SZ_OFF, 32'h0000_0C08);
      cmd(OP_CREATE); chk("exact fit", rd[3:1], 3'b100);
      wr(MASK_HI_OFF, 32'h8000_0000);
      cmd(OP_CREATE); chk("bit 63", rd[1], 1'b1);
      wr(MASK_HI_OFF, 32'h0);
      wr(MISC_SZ_OFF, 32'h0000_0C09);
      cmd(OP_CREATE); chk("too small", rd[3:1], 3'b001);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
